// >>> src/abs_store_pkg.sv
// constants, types and state layout for the guarded abs and displaced store unit
package abs_store_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int          WORD_W   = 32;
  localparam int          MOD_W    = 7;
  localparam int          LANES    = 4;
  localparam int          BYTE_W   = 8;

  // ----------------------------------------------------------------
  // displacement scaling (shift of the modifier) and access sizes
  // ----------------------------------------------------------------
  localparam int          BYTE_SHIFT = 0;
  localparam int          HALF_SHIFT = 1;
  localparam int          WORD_SHIFT = 2;
  localparam logic [2:0]  BYTE_BYTES = 3'h1;
  localparam logic [2:0]  HALF_BYTES = 3'h2;
  localparam logic [2:0]  WORD_BYTES = 3'h4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic        FLAG_RESET = 1'b0;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [3:0]  STRB_RESET = 4'h0;

  // ----------------------------------------------------------------
  // operations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    op_abs,
    op_byte_store_disp,
    op_halfword_store_disp,
    op_word_store_disp
  } op_e;

  // ----------------------------------------------------------------
  // whole state of the unit
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        result_write;
    logic [31:0] result_data;
    logic        store_write;
    logic [31:0] store_addr;
    logic [3:0]  store_strobe;
    logic [31:0] store_data;
    logic        misaligned_store_flag;
    logic        trap_pending;
    logic        exception_request;
  } state_s;

endpackage : abs_store_pkg

// >>> src/guarded_abs_and_displaced_store.sv
// guarded integer absolute value and displaced byte/halfword/word stores
//
// Behaviour
// - abs writes negation of second source when negative, else copies it.
// - abs result is unsigned 32 bits; most negative input passes unchanged.
// - abs destination written only when guard lsb is one.
// - halfword store writes low 16 bits at second source plus displacement.
// - halfword and word stores order bytes by the byte-order bit.
// - misaligned halfword or word store sets the misaligned-store flag.
// - misaligned store with trap enabled requests exception at next interruptible jump.
// - word store writes all 32 bits at second source plus displacement.
// - byte store writes low 8 bits at second source plus displacement.
// - byte store ignores the byte-order bit.
// - guarded-true aligned store updates memory and cache; a misaligned one writes nothing.
// - guarded-false store has no side effect at all.
`timescale 1ns/10ps
`default_nettype none

module guarded_abs_and_displaced_store
  import abs_store_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // issue side
  input  wire logic        issue_valid,
  input  wire op_e         issue_op,
  input  wire logic        guard_bit,
  input  wire logic [31:0] first_source,
  input  wire logic [31:0] second_source,
  input  wire logic [6:0]  modifier,
  // processor control status word bits
  input  wire logic        little_endian,
  input  wire logic        misaligned_store_trap_enable,
  input  wire logic        flag_clear,
  input  wire logic        interruptible_jump,
  // register file write
  output logic             result_write,
  output logic [31:0]      result_data,
  // data cache write
  output logic             store_write,
  output logic [31:0]      store_addr,
  output logic [3:0]       store_strobe,
  output logic [31:0]      store_data,
  // status and exception
  output logic             misaligned_store_flag,
  output logic             exception_request
);

  // ----------------------------------------------------------------
  // address formation
  // ----------------------------------------------------------------
  logic [31:0] disp_ext;
  logic [31:0] disp;
  logic [31:0] addr;
  logic [2:0]  nbytes;
  logic [1:0]  offset;
  logic        is_store;
  logic        misaligned;

  assign disp_ext = {{(WORD_W-MOD_W){modifier[MOD_W-1]}}, modifier};
  assign is_store = (issue_op != op_abs);
  assign addr     = second_source + disp;
  assign offset   = addr[1:0];

  always_comb begin
    unique case (issue_op)
      op_halfword_store_disp: begin
        disp   = disp_ext << HALF_SHIFT;
        nbytes = HALF_BYTES;
      end
      op_word_store_disp: begin
        disp   = disp_ext << WORD_SHIFT;
        nbytes = WORD_BYTES;
      end
      op_abs, op_byte_store_disp: begin
        disp   = disp_ext << BYTE_SHIFT;
        nbytes = BYTE_BYTES;
      end
    endcase
  end

  // word stores need both low bits clear, halfword stores bit 0
  assign misaligned = ((issue_op == op_halfword_store_disp) && addr[0])
                   || ((issue_op == op_word_store_disp) && (addr[1:0] != 2'h0));

  // ----------------------------------------------------------------
  // byte lanes of the aligned word that holds the access
  // ----------------------------------------------------------------
  logic [3:0]  lane_hit;
  logic [31:0] lane_data;

  for (genvar k = 0; k < LANES; k++) begin : g_lane
    localparam logic [2:0] LANE = 3'(k);
    logic [1:0] rel;
    logic [1:0] pick;
    assign lane_hit[k] = (LANE >= {1'b0, offset}) && ((LANE - {1'b0, offset}) < nbytes);
    assign rel         = 2'(LANE - {1'b0, offset});
    // a single byte gives pick 0 either way, so order cannot matter
    assign pick        = little_endian ? rel : 2'(nbytes - 3'h1 - {1'b0, rel});
    assign lane_data[k*BYTE_W +: BYTE_W] = first_source[{pick, 3'b000} +: BYTE_W];
  end

  // ----------------------------------------------------------------
  // absolute value
  // ----------------------------------------------------------------
  logic [31:0] abs_value;

  // first source is the zero register and plays no part
  assign abs_value = second_source[WORD_W-1] ? (~second_source + 32'h0000_0001)
                                             : second_source;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  state_s st;
  state_s next_st;
  logic   mis_event;

  assign mis_event = issue_valid && is_store && guard_bit && misaligned;

  always_comb begin
    next_st                   = st;
    next_st.result_write      = issue_valid && (issue_op == op_abs) && guard_bit;
    next_st.store_write       = 1'b0;
    next_st.exception_request = 1'b0;
    if (next_st.result_write) begin
      next_st.result_data = abs_value;
    end
    // undefined memory effect on misalignment: the write is dropped
    if (issue_valid && is_store && guard_bit && !misaligned) begin
      next_st.store_write  = 1'b1;
      next_st.store_addr   = addr;
      next_st.store_strobe = lane_hit;
      next_st.store_data   = lane_data;
    end
    // set wins over software clear
    next_st.misaligned_store_flag = (st.misaligned_store_flag && !flag_clear) || mis_event;
    // deferred until an interruptible jump; a store in the jump cycle waits for the next
    next_st.exception_request = st.trap_pending && interruptible_jump;
    next_st.trap_pending      = (st.trap_pending && !interruptible_jump)
                             || (mis_event && misaligned_store_trap_enable);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st.result_write          <= FLAG_RESET;
      st.result_data           <= DATA_RESET;
      st.store_write           <= FLAG_RESET;
      st.store_addr            <= DATA_RESET;
      st.store_strobe          <= STRB_RESET;
      st.store_data            <= DATA_RESET;
      st.misaligned_store_flag <= FLAG_RESET;
      st.trap_pending          <= FLAG_RESET;
      st.exception_request     <= FLAG_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign result_write          = st.result_write;
  assign result_data           = st.result_data;
  assign store_write           = st.store_write;
  assign store_addr            = st.store_addr;
  assign store_strobe          = st.store_strobe;
  assign store_data            = st.store_data;
  assign misaligned_store_flag = st.misaligned_store_flag;
  assign exception_request     = st.exception_request;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_abs_issue;
    issue_valid && (issue_op == op_abs);
  endsequence

  sequence s_store_issue;
    issue_valid && (issue_op != op_abs);
  endsequence

  sequence s_mis_trap;
    s_store_issue ##0 (guard_bit && misaligned && misaligned_store_trap_enable);
  endsequence

  property p_abs_value;
    s_abs_issue ##0 guard_bit |=> result_write
      && (result_data == ($past(second_source[31]) ? 32'(-$past(second_source))
                                                   : $past(second_source)));
  endproperty
  a_abs_value: assert property (p_abs_value) else $error("abs result wrong");

  property p_abs_min;
    s_abs_issue ##0 (guard_bit && second_source == 32'h8000_0000)
      |=> result_data == 32'h8000_0000;
  endproperty
  a_abs_min: assert property (p_abs_min) else $error("most negative abs altered");

  property p_abs_guard;
    s_abs_issue ##0 !guard_bit |=> !result_write;
  endproperty
  a_abs_guard: assert property (p_abs_guard) else $error("abs written with false guard");

  property p_store_guard;
    s_store_issue ##0 (!guard_bit && !flag_clear && !interruptible_jump)
      |=> !store_write && $stable(misaligned_store_flag) && !$rose(st.trap_pending);
  endproperty
  a_store_guard: assert property (p_store_guard) else $error("false guard store had effect");

  property p_mis_flag;
    s_store_issue ##0 (guard_bit && misaligned) |=> misaligned_store_flag && !store_write;
  endproperty
  a_mis_flag: assert property (p_mis_flag) else $error("misaligned flag not set");

  property p_trap;
    s_mis_trap ##1 (!interruptible_jump [*2] ##1 interruptible_jump) |=> exception_request;
  endproperty
  a_trap: assert property (p_trap) else $error("trap not requested at jump");

  property p_no_spurious_trap;
    !st.trap_pending |=> !exception_request;
  endproperty
  a_no_spurious_trap: assert property (p_no_spurious_trap) else $error("spurious exception");

  // address rebuilt from the raw field, not from the adder above
  property p_store_addr;
    store_write |-> store_addr == $past(second_source)
      + (32'($signed($past(modifier)))
         << (($past(issue_op) == op_word_store_disp)     ? WORD_SHIFT
           : ($past(issue_op) == op_halfword_store_disp) ? HALF_SHIFT : BYTE_SHIFT));
  endproperty
  a_store_addr: assert property (p_store_addr) else $error("store address wrong");

  property p_word_store;
    s_store_issue ##0 (issue_op == op_word_store_disp && guard_bit && !misaligned)
      |=> store_strobe == 4'hF && store_data == ($past(little_endian) ? $past(first_source)
          : {$past(first_source[7:0]), $past(first_source[15:8]),
             $past(first_source[23:16]), $past(first_source[31:24])});
  endproperty
  a_word_store: assert property (p_word_store) else $error("word store lanes wrong");

  property p_byte_store;
    s_store_issue ##0 (issue_op == op_byte_store_disp && guard_bit)
      |=> store_write && $onehot(store_strobe)
          && store_data[{store_addr[1:0], 3'b000} +: 8] == $past(first_source[7:0]);
  endproperty
  a_byte_store: assert property (p_byte_store) else $error("byte store wrong");

  // halfword lanes sit at bit 0 or bit 16 of the aligned word
  sequence s_half_ok;
    s_store_issue ##0 (issue_op == op_halfword_store_disp && guard_bit && !misaligned);
  endsequence

  property p_half_store;
    s_half_ok |=> store_write && store_strobe == (store_addr[1] ? 4'hC : 4'h3)
      && store_data[{store_addr[1], 4'h0} +: 16]
         == ($past(little_endian) ? $past(first_source[15:0])
                                  : {$past(first_source[7:0]), $past(first_source[15:8])});
  endproperty
  a_half_store: assert property (p_half_store) else $error("halfword store lanes wrong");

  // the destination is a register: it must not drift between writes
  property p_abs_hold;
    !result_write |-> $stable(result_data);
  endproperty
  a_abs_hold: assert property (p_abs_hold) else $error("abs destination changed unwritten");

  property p_store_no_result;
    s_store_issue |=> !result_write;
  endproperty
  a_store_no_result: assert property (p_store_no_result) else $error("store wrote result");

  property p_abs_no_store;
    s_abs_issue ##0 !flag_clear |=> !store_write && $stable(misaligned_store_flag);
  endproperty
  a_abs_no_store: assert property (p_abs_no_store) else $error("abs touched the store port");

  // a clear loses to a misaligned store in the same cycle
  property p_flag_clear;
    flag_clear && !(issue_valid && (issue_op != op_abs) && guard_bit && misaligned)
      |=> !misaligned_store_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag clear ignored");

  property p_flag_sticky;
    misaligned_store_flag && !flag_clear |=> misaligned_store_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped by itself");

  // without the enable a misalignment only marks the flag
  property p_trap_off;
    s_store_issue ##0 (guard_bit && misaligned && !misaligned_store_trap_enable
                       && !st.trap_pending) |=> !st.trap_pending;
  endproperty
  a_trap_off: assert property (p_trap_off) else $error("trap armed while disabled");

endmodule : guarded_abs_and_displaced_store

`default_nettype wire

// >>> test/dcache_model.sv
// data cache and memory model on the far side of the store port
`timescale 1ns/10ps
`default_nettype none
module dcache_model (
  // clock
  input wire logic        mclk,
  // store port
  input wire logic        store_write,
  input wire logic [31:0] store_addr,
  input wire logic [3:0]  store_strobe,
  input wire logic [31:0] store_data
);
  logic [7:0] mem [logic [31:0]];
  int         writes = 0;

  // one write per store, lanes of the aligned word
  always @(posedge mclk) begin
    if (store_write === 1'b1) begin
      writes++;
      for (int k = 0; k < 4; k++) begin
        if (store_strobe[k])
          mem[{store_addr[31:2], 2'h0} + k] = store_data[8*k +: 8];
      end
    end
  end

  function automatic logic [7:0] peek(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : 8'hXX;
  endfunction
endmodule // dcache_model
`default_nettype wire

// >>> test/guarded_abs_and_displaced_store_test.sv
// self-checking bench for the guarded abs and displaced store unit
`timescale 1ns/10ps
`default_nettype none
module guarded_abs_and_displaced_store_test;
  import abs_store_pkg::*;
  logic        mclk, resetn, issue_valid, guard_bit, little_endian, flag_clear;
  logic        misaligned_store_trap_enable, interruptible_jump;
  op_e         issue_op;
  logic [31:0] first_source, second_source, result_data, store_addr, store_data, r;
  logic [6:0]  modifier;
  logic        result_write, store_write, misaligned_store_flag, exception_request;
  logic [3:0]  store_strobe;
  logic [31:0] seed = 32'h904600A1;
  logic        exp_flag = 1'b0;
  logic [31:0] exp_res  = 32'h0;
  int          errors = 0, cmp_count = 0, cycles = 0;

  guarded_abs_and_displaced_store dut_u (
    .mclk, .resetn, .issue_valid, .issue_op, .guard_bit, .first_source, .second_source,
    .modifier, .little_endian, .misaligned_store_trap_enable, .flag_clear,
    .interruptible_jump, .result_write, .result_data, .store_write, .store_addr,
    .store_strobe, .store_data, .misaligned_store_flag, .exception_request);
  dcache_model mem_u (.mclk, .store_write, .store_addr, .store_strobe, .store_data);

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ceiling far above the ~460 cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic results();
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic void exp_store(input op_e op, input logic le, input logic [31:0] s1, s2,
                                    input logic [6:0] m, output logic ok,
                                    output logic [31:0] a, output logic [3:0] st,
                                    output logic [31:0] d);
    int         n;
    logic [1:0] lane;
    n = (op == op_word_store_disp) ? 4 : (op == op_halfword_store_disp) ? 2 : 1;
    a = s2 + ({{25{m[6]}}, m} << (n >> 1));
    ok = (a & (n - 1)) == 0;
    st = 4'h0;
    d = 32'h0;
    for (int i = 0; i < n; i++) begin
      lane = a[1:0] + 2'(i);
      st[lane] = 1'b1;
      d[8*lane +: 8] = s1[8*((le || n == 1) ? i : n - 1 - i) +: 8];
    end
  endfunction

  task automatic run(input op_e op, input logic g, le, input logic [31:0] s1, s2,
                     input logic [6:0] m);
    logic        ok;
    logic [31:0] a, d, mask;
    logic [3:0]  st;
    issue_valid = 1'b1;
    issue_op = op;
    guard_bit = g;
    little_endian = le;
    first_source = s1;
    second_source = s2;
    modifier = m;
    exp_store(op, le, s1, s2, m, ok, a, st, d);
    // set wins over a clear in the same cycle; abs always comes back ok
    exp_flag = (exp_flag && !flag_clear) || (g && !ok);
    mask = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    @(posedge mclk);
    #1;
    if (op == op_abs) begin
      check(result_write, g);
      if (g)
        exp_res = s2[31] ? -s2 : s2;
      check(result_data, exp_res);
      check(store_write, 1'b0);
    end else begin
      check(store_write, g && ok);
      check(result_write, 1'b0);
      if (g && ok) begin
        check(store_addr, a);
        check(store_strobe, st);
        check(store_data & mask, d);
      end
    end
    check(misaligned_store_flag, exp_flag);
  endtask

  task automatic idle(input int n);
    issue_valid = 1'b0;
    repeat (n) begin
      @(posedge mclk);
      #1;
      check(exception_request, 1'b0);
    end
  endtask

  task automatic jump(input logic want);
    issue_valid = 1'b0;
    interruptible_jump = 1'b1;
    @(posedge mclk);
    #1;
    interruptible_jump = 1'b0;
    check(exception_request, want);
  endtask

  task automatic clr();
    issue_valid = 1'b0;
    flag_clear = 1'b1;
    @(posedge mclk);
    #1;
    flag_clear = 1'b0;
    exp_flag = 1'b0;
    check(misaligned_store_flag, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    issue_valid = 1'b0;
    issue_op = op_abs;
    guard_bit = 1'b0;
    first_source = 32'h0;
    second_source = 32'h0;
    modifier = 7'h00;
    little_endian = 1'b0;
    misaligned_store_trap_enable = 1'b0;
    flag_clear = 1'b0;
    interruptible_jump = 1'b0;
    repeat (10) @(posedge mclk);
    #1;
    resetn = 1'b1;
    // abs always gets the zero register first
    run(op_abs, 1'b1, 1'b0, 32'h0, 32'hFFFFFFFF, 7'h00);
    run(op_abs, 1'b0, 1'b0, 32'h0, 32'hFFFFFFF4, 7'h00);
    run(op_abs, 1'b1, 1'b0, 32'h0, 32'hFFFFFFF4, 7'h00);
    run(op_abs, 1'b1, 1'b0, 32'h0, 32'h80000000, 7'h00);
    run(op_abs, 1'b1, 1'b0, 32'h0, 32'h00000001, 7'h00);
    run(op_halfword_store_disp, 1'b1, 1'b0, 32'h44332211, 32'h00000CFE, 7'h01);
    run(op_word_store_disp, 1'b1, 1'b0, 32'h44332211, 32'h00000CFC, 7'h01);
    run(op_byte_store_disp, 1'b1, 1'b1, 32'h44332211, 32'h00000D00, 7'h03);
    run(op_word_store_disp, 1'b0, 1'b0, 32'hAABBCCDD, 32'h00000D0B, 7'h7E);
    run(op_word_store_disp, 1'b1, 1'b0, 32'hAABBCCDD, 32'h00000D0C, 7'h7E);
    run(op_halfword_store_disp, 1'b1, 1'b0, 32'hAABBCCDD, 32'h00000D06, 7'h7E);
    run(op_byte_store_disp, 1'b1, 1'b1, 32'hAABBCCDD, 32'h00000D02, 7'h7C);
    idle(1);
    check(mem_u.writes, 32'd6);
    check(mem_u.peek(32'hD00), 8'h44);
    check(mem_u.peek(32'hD03), 8'hDD);
    check(mem_u.peek(32'hD04), 8'hAA);
    check(mem_u.peek(32'hCFE), 8'hDD);
    flag_clear = 1'b1;
    run(op_halfword_store_disp, 1'b1, 1'b0, 32'h00005678, 32'h00000D03, 7'h00);
    flag_clear = 1'b0;
    misaligned_store_trap_enable = 1'b1;
    run(op_halfword_store_disp, 1'b1, 1'b0, 32'h00001234, 32'h00000D01, 7'h00);
    idle(2);
    jump(1'b1);
    idle(1);
    jump(1'b0);
    clr();
    misaligned_store_trap_enable = 1'b0;
    run(op_word_store_disp, 1'b1, 1'b0, 32'h0, 32'h00000D02, 7'h00);
    jump(1'b0);
    clr();
    for (int i = 0; i < 400; i++) begin
      r = rnd();
      misaligned_store_trap_enable = r[20];
      if (r[31:28] == 4'h0)
        clr();
      flag_clear = (r[27:26] == 2'h0);
      run(op_e'(r[1:0]), r[4:2] != 3'h0, r[5], r[1:0] == 2'h0 ? 32'h0 : rnd(), rnd(), r[12:6]);
    end
    flag_clear = 1'b0;
    idle(1);
    // mid-run reset: every output drops at once, then work resumes at once
    resetn = 1'b0;
    @(posedge mclk);
    #1;
    check({result_write, store_write, store_strobe}, 32'h0);
    check(result_data | store_addr | store_data, 32'h0);
    check({misaligned_store_flag, exception_request}, 32'h0);
    resetn = 1'b1;
    exp_flag = 1'b0;
    exp_res = 32'h0;
    run(op_abs, 1'b1, 1'b0, 32'h0, 32'h00000001, 7'h00);
    run(op_word_store_disp, 1'b1, 1'b1, 32'h44332211, 32'h00000CFC, 7'h01);
    idle(1);
    results();
  end
endmodule // guarded_abs_and_displaced_store_test
`default_nettype wire
